/* hdl/analog_compare_control.sv */
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
// Function
// R1: Software enables reference buffer before choosing internal reference.
// R2: Route select feeds comparator output into timer capture channel zero.
// R3: Route select disconnects timer channel zero pin externally.
// R4: Comparator one goes to timer one, two to timer two.
// R5: One clock gate bit for both comparators, set by every reset.
// R6: Both comparator requests share one interrupt line.
// R7: Handler reads both flags to find the source.
// R8: Enabled comparator keeps working in wait mode and can wake.
// R9: Software should disable unneeded comparators before wait.
// R10: Event edge selectable: rising, falling or either.
// R11: Select replaces external positive input with internal reference.
// R12: Output pin driven with comparator level when pin enable set.
// R13: Comparators disabled in every stop mode, never wake from stop.
// R14: Deep stop powers down; afterwards all state equals reset. Code resets only the channels, not route, gate or buffer.
// R15: Light stop halts clocks, keeps registers, detects no events.
// R16: Light stop exit by reset resets; by interrupt resumes state.
// R17: Edge field: 00 falling, 01 rising, 10 falling, 11 either.
// R18: Flag sets on selected edge; write one clears, zero keeps.
// R19: Request asserted while flag and interrupt enable both set.
// R20: Level bit shows output, resets zero, zero while disabled.
// R21: Comparator output synchronised to bus clock before edge detection.
// R22: Edges from previous sample; no flag setting while clock gated.
module analog_compare_control
  import analog_compare_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_analog_out,
  input wire logic i_wait_mode,
  input wire logic i_light_stop_mode,
  input wire logic i_deep_stop_mode,
  input wire logic [1:0] i_timer_pin_in,
  output logic [1:0] o_capture_in,
  output logic [1:0] o_timer_pin_connect,
  output logic [1:0] o_comparator_output_pin,
  output logic [1:0] o_comparator_output_pin_oe,
  output logic [1:0] o_analog_enable,
  output logic [1:0] o_reference_select,
  output logic o_reference_buffer_enable,
  output logic o_irq
);
  // ****************************************************
  // Power state tracking
  // ****************************************************
  power_state_t power_state;
  power_state_t next_power_state;
  logic deep_reset;
  logic channel_rst;
  logic in_stop;

  // Power state selection
  always_comb begin
    case (1'b1)
      i_deep_stop_mode: next_power_state = PWR_DEEP_STOP;
      i_light_stop_mode: next_power_state = PWR_LIGHT_STOP;
      default: next_power_state = PWR_RUN;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      power_state <= PWR_RUN;
    end else begin
      power_state <= next_power_state;
    end
  end

  // Deep stop holds channels in reset; reset on light stop exit resets too
  assign deep_reset = (power_state == PWR_DEEP_STOP) | i_deep_stop_mode; // see R14
  assign channel_rst = i_rst | deep_reset; // see R14 R16
  assign in_stop = i_light_stop_mode | i_deep_stop_mode;

  // ****************************************************
  // System registers
  // ****************************************************
  logic [1:0] capture_route_select;
  logic clock_gate_reg_two;
  logic reference_buffer_enable;
  logic clock_on;
  logic wr_status_one;
  logic wr_status_two;
  logic wr_options;
  logic wr_gate;
  logic wr_power;

  // Address decode
  assign wr_status_one = i_write & (i_addr == ADDR_STATUS_ONE);
  assign wr_status_two = i_write & (i_addr == ADDR_STATUS_TWO);
  assign wr_options = i_write & (i_addr == ADDR_SYS_OPTIONS);
  assign wr_gate = i_write & (i_addr == ADDR_CLOCK_GATE);
  assign wr_power = i_write & (i_addr == ADDR_POWER_MODE);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      capture_route_select <= RESET_ROUTE;
      clock_gate_reg_two <= RESET_CLOCK_GATE; // see R5
      reference_buffer_enable <= RESET_REF_BUFFER;
    end else begin
      if (wr_options) begin
        capture_route_select <= i_wdata[BIT_ROUTE_TWO:BIT_ROUTE_ONE];
      end
      if (wr_gate) begin
        clock_gate_reg_two <= i_wdata[BIT_CLOCK_GATE];
      end
      if (wr_power) begin
        reference_buffer_enable <= i_wdata[BIT_REF_BUFFER];
      end
    end
  end

  // Clocks stop in any stop mode; wait mode leaves them running
  assign clock_on = clock_gate_reg_two & ~in_stop; // see R5 R15 R8

  // ****************************************************
  // Comparator channels
  // ****************************************************
  logic [7:0] status [2];
  logic [1:0] active;
  logic [1:0] level;
  logic [1:0] irq;
  logic [1:0] ref_select;
  logic [1:0] pin_enable;
  logic [1:0] ch_write;

  // Channel register writes land only while clocked
  assign ch_write = {wr_status_two, wr_status_one} & {2{clock_on}}; // see R15

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_channel
      comparator_channel u_channel (
        .i_clock(i_clock),
        .i_rst(channel_rst),
        .i_analog_out(i_analog_out[g]),
        .i_clock_on(clock_on),
        .i_write(ch_write[g]),
        .i_wdata(i_wdata),
        .o_status(status[g]),
        .o_active(active[g]),
        .o_level(level[g]),
        .o_irq(irq[g]),
        .o_ref_select(ref_select[g]),
        .o_pin_enable(pin_enable[g])
      );
    end
  endgenerate

  // ****************************************************
  // Outputs to analog, timers and pins
  // ****************************************************
  logic [1:0] run_level;
  logic [1:0] next_pin;
  logic [1:0] next_capture;
  logic [1:0] pin_reg;
  logic [1:0] capture_reg;

  // Comparator circuits off in stop, reference buffer left on; enable survives wait
  assign o_analog_enable = active & {2{~in_stop}}; // see R13 R8
  assign o_reference_select = ref_select; // see R11
  assign o_reference_buffer_enable = reference_buffer_enable;
  assign run_level = level & {2{~in_stop}};
  // Bit 0 to timer one, bit 1 to timer two
  assign next_capture = (capture_route_select & run_level) |
    (~capture_route_select & i_timer_pin_in); // see R2 R4
  assign next_pin = run_level & pin_enable; // see R12
  assign o_timer_pin_connect = ~capture_route_select; // see R3
  assign o_comparator_output_pin_oe = pin_enable; // see R12

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_reg <= 2'h0;
      capture_reg <= 2'h0;
    end else begin
      pin_reg <= next_pin;
      capture_reg <= next_capture;
    end
  end

  assign o_comparator_output_pin = pin_reg;
  assign o_capture_in = capture_reg;

  // Shared request line
  assign o_irq = |irq; // see R6 R7

  // ****************************************************
  // Read port
  // ****************************************************
  logic [7:0] next_rdata;
  logic [7:0] rdata_reg;

  always_comb begin
    case (i_addr)
      ADDR_STATUS_ONE: next_rdata = status[0];
      ADDR_STATUS_TWO: next_rdata = status[1];
      ADDR_SYS_OPTIONS: next_rdata = {6'h00, capture_route_select};
      ADDR_CLOCK_GATE: next_rdata = {7'h00, clock_gate_reg_two};
      ADDR_POWER_MODE: next_rdata = {7'h00, reference_buffer_enable}; // see R1
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else if (i_read) begin
      rdata_reg <= next_rdata;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign o_rdata = rdata_reg;
endmodule : analog_compare_control

/* hdl/analog_compare_pkg.sv */
package analog_compare_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [2:0] ADDR_STATUS_ONE = 3'h0; // Comparator one status/control
  localparam logic [2:0] ADDR_STATUS_TWO = 3'h1; // Comparator two status/control
  localparam logic [2:0] ADDR_SYS_OPTIONS = 3'h2; // Capture route selects
  localparam logic [2:0] ADDR_CLOCK_GATE = 3'h3; // Bus clock gate
  localparam logic [2:0] ADDR_POWER_MODE = 3'h4; // Reference buffer enable

  // ****************************************************
  // Status/control and system register field positions
  // ****************************************************
  localparam int BIT_ENABLE = 7;
  localparam int BIT_REF_SELECT = 6;
  localparam int BIT_FLAG = 5;
  localparam int BIT_IRQ_ENABLE = 4;
  localparam int BIT_LEVEL = 3;
  localparam int BIT_PIN_ENABLE = 2;
  localparam int BIT_EDGE_HI = 1;
  localparam int BIT_EDGE_LO = 0;
  localparam int BIT_ROUTE_ONE = 0;
  localparam int BIT_ROUTE_TWO = 1;
  localparam int BIT_CLOCK_GATE = 0;
  localparam int BIT_REF_BUFFER = 0;

  // ****************************************************
  // Reset values and edge encodings
  // ****************************************************
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [1:0] RESET_ROUTE = 2'h0;
  localparam logic RESET_CLOCK_GATE = 1'b1;
  localparam logic RESET_REF_BUFFER = 1'b0;
  localparam logic [1:0] EDGE_FALL_A = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL_B = 2'h2;
  localparam logic [1:0] EDGE_EITHER = 2'h3;

  // Power states
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_LIGHT_STOP = 3'b010,
    PWR_DEEP_STOP = 3'b100
  } power_state_t;
endpackage : analog_compare_pkg

/* hdl/comparator_channel.sv */
`timescale 1ns/100ps
module comparator_channel
  import analog_compare_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_analog_out,
  input wire logic i_clock_on,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_status,
  output logic o_active,
  output logic o_level,
  output logic o_irq,
  output logic o_ref_select,
  output logic o_pin_enable
);
  // ****************************************************
  // One comparator's control register and event logic
  // ****************************************************
  logic comparator_enable;
  logic reference_select;
  logic compare_event_flag;
  logic compare_interrupt_enable;
  logic output_pin_enable;
  logic [1:0] event_edge_select;
  logic sync_level;
  logic prev_level;
  logic comparator_level;
  logic rise;
  logic fall;
  logic hit;
  logic flag_clear;

  level_sync u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_analog_out),
    .o_level(sync_level)
  ); // see R21

  // Level reads zero while disabled, edges only while clocked
  assign comparator_level = comparator_enable & sync_level; // see R20
  assign rise = comparator_level & ~prev_level; // see R22
  assign fall = ~comparator_level & prev_level;
  assign hit = i_clock_on & comparator_enable & ( // see R22 R10 R15
    (event_edge_select == EDGE_EITHER) ? (rise | fall) :
    (event_edge_select == EDGE_RISE) ? rise : fall); // see R17
  assign flag_clear = i_write & i_wdata[BIT_FLAG];

  // Register and edge history; set beats clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      comparator_enable <= RESET_STATUS[BIT_ENABLE];
      reference_select <= RESET_STATUS[BIT_REF_SELECT];
      compare_event_flag <= RESET_STATUS[BIT_FLAG];
      compare_interrupt_enable <= RESET_STATUS[BIT_IRQ_ENABLE];
      output_pin_enable <= RESET_STATUS[BIT_PIN_ENABLE];
      event_edge_select <= RESET_STATUS[BIT_EDGE_HI:BIT_EDGE_LO];
      prev_level <= 1'b0;
    end else begin
      if (i_clock_on) begin
        prev_level <= comparator_level;
      end
      if (i_write) begin
        comparator_enable <= i_wdata[BIT_ENABLE];
        reference_select <= i_wdata[BIT_REF_SELECT];
        compare_interrupt_enable <= i_wdata[BIT_IRQ_ENABLE];
        output_pin_enable <= i_wdata[BIT_PIN_ENABLE];
        event_edge_select <= i_wdata[BIT_EDGE_HI:BIT_EDGE_LO];
      end
      if (hit) begin
        compare_event_flag <= 1'b1; // see R18
      end else if (flag_clear) begin
        compare_event_flag <= 1'b0; // see R18
      end
    end
  end

  assign o_status = {comparator_enable, reference_select, compare_event_flag,
    compare_interrupt_enable, comparator_level, output_pin_enable, event_edge_select};
  assign o_active = comparator_enable;
  assign o_level = comparator_level;
  assign o_irq = compare_event_flag & compare_interrupt_enable; // see R19
  assign o_ref_select = reference_select;
  assign o_pin_enable = output_pin_enable;
endmodule : comparator_channel

/* hdl/level_sync.sv */
`timescale 1ns/100ps
module level_sync
  import analog_compare_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_level
);
  // ****************************************************
  // Three stage synchroniser with agreement filter
  // ****************************************************
  logic meta;
  logic stage_two;
  logic stage_three;

  // Capture chain
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta <= 1'b0;
      stage_two <= 1'b0;
      stage_three <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta <= i_async;
      stage_two <= meta;
      stage_three <= stage_two;
      if (stage_two == stage_three) begin
        o_level <= stage_three;
      end
    end
  end
endmodule : level_sync

/* verif/analog_compare_control_tb.sv */
`timescale 1ns/100ps
module analog_compare_control_tb;
  import analog_compare_pkg::*;
  // ********
  // Bench
  // ********
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [1:0] i_analog_out = 2'h0;
  logic i_wait_mode = 1'b0;
  logic i_light_stop_mode = 1'b0;
  logic i_deep_stop_mode = 1'b0;
  wire [1:0] pin_in, cap, conn, opin, oe, aen, rsel;
  wire [7:0] o_rdata;
  wire buf_en, o_irq;
  logic [7:0] exp_q[$];
  logic [7:0] cfg, fl, lvl;
  logic rd_prev = 1'b0;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  integer seed = 32'h9aeeda7c;
  analog_compare_control dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_analog_out(i_analog_out), .i_wait_mode(i_wait_mode),
    .i_light_stop_mode(i_light_stop_mode), .i_deep_stop_mode(i_deep_stop_mode),
    .i_timer_pin_in(pin_in), .o_capture_in(cap), .o_timer_pin_connect(conn),
    .o_comparator_output_pin(opin), .o_comparator_output_pin_oe(oe),
    .o_analog_enable(aen), .o_reference_select(rsel),
    .o_reference_buffer_enable(buf_en), .o_irq(o_irq));
  timer_pin_model pin_u (.i_clock(i_clock), .i_pin_connect(conn), .o_pin_level(pin_in));
  function automatic logic [7:0] z2(input logic [1:0] v);
    return {6'h00, v};
  endfunction : z2
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    i_write <= w;
    i_read <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
  endtask : bus
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask : idle
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // Clock and hang limit
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // Read data against the oldest note
  always @(negedge i_clock) begin
    if (rd_prev) check("read data", o_rdata, exp_q.pop_front());
    rd_prev = i_read;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int a = 0; a < 6; a++) rd(a[2:0], (a == 3) ? 8'h01 : 8'h00);
    for (int ch = 0; ch < 2; ch++) begin
      i_wait_mode <= ch[0];
      for (int m = 0; m < 4; m++) begin
        cfg = 8'h90 | m[7:0];
        bus(1'b1, 1'b0, ch[2:0], cfg);
        i_analog_out[ch] <= 1'b1;
        idle(8);
        fl = m[0] ? 8'h20 : 8'h00;
        check("irq", z2({1'b0, o_irq}), z2({1'b0, fl[5]}));
        rd(ch[2:0], cfg | fl | 8'h08);
        rd(ch ? 3'h0 : 3'h1, 8'h00);
        bus(1'b1, 1'b0, ch[2:0], cfg | 8'h20);
        i_analog_out[ch] <= 1'b0;
        idle(8);
        rd(ch[2:0], cfg | ((m == 1) ? 8'h00 : 8'h20));
        bus(1'b1, 1'b0, ch[2:0], 8'h20);
      end
    end
    bus(1'b1, 1'b0, ADDR_STATUS_ONE, 8'h84);
    bus(1'b1, 1'b0, ADDR_STATUS_TWO, 8'h84);
    for (int r = 0; r < 4; r++) begin
      lvl = 8'($random(seed));
      i_analog_out <= lvl[1:0];
      bus(1'b1, 1'b0, ADDR_SYS_OPTIONS, r[7:0]);
      idle(8);
      check("pin connect", z2(conn), z2(~r[1:0]));
      check("capture", z2(cap & r[1:0]), z2(lvl[1:0] & r[1:0]));
      check("output pin", z2(opin), z2(lvl[1:0]));
      check("pin enable", z2(oe), 8'h03);
      rd(ADDR_SYS_OPTIONS, r[7:0]);
    end
    bus(1'b1, 1'b0, ADDR_POWER_MODE, 8'h01);
    bus(1'b1, 1'b0, ADDR_STATUS_ONE, 8'hc0);
    i_analog_out <= 2'h0;
    idle(8);
    check("reference", {5'h00, buf_en, rsel}, 8'h05);
    // Clear comparator one's flag left by the falling edges above in the same write that enables the request
    bus(1'b1, 1'b0, ADDR_STATUS_ONE, 8'hb3);
    bus(1'b1, 1'b0, ADDR_CLOCK_GATE, 8'h00);
    i_analog_out[0] <= 1'b1;
    idle(8);
    i_analog_out[0] <= 1'b0;
    bus(1'b1, 1'b0, ADDR_STATUS_ONE, 8'h00);
    idle(8);
    check("gated", z2({aen[0], o_irq}), 8'h02);
    bus(1'b1, 1'b0, ADDR_CLOCK_GATE, 8'h01);
    i_analog_out[0] <= 1'b1;
    idle(8);
    i_light_stop_mode <= 1'b1;
    idle(3);
    check("stop enable", z2(aen), 8'h00);
    bus(1'b1, 1'b0, ADDR_STATUS_ONE, 8'hb3);
    i_light_stop_mode <= 1'b0;
    idle(2);
    check("irq kept", z2({1'b0, o_irq}), 8'h01);
    bus(1'b1, 1'b0, ADDR_STATUS_ONE, 8'hb3);
    i_light_stop_mode <= 1'b1;
    i_analog_out[0] <= 1'b0;
    idle(4);
    i_analog_out[0] <= 1'b1;
    idle(4);
    i_light_stop_mode <= 1'b0;
    idle(8);
    rd(ADDR_STATUS_ONE, 8'h9b);
    i_deep_stop_mode <= 1'b1;
    idle(3);
    i_deep_stop_mode <= 1'b0;
    idle(3);
    rd(ADDR_STATUS_ONE, 8'h00);
    rd(ADDR_SYS_OPTIONS, 8'h03);
    bus(1'b1, 1'b0, ADDR_CLOCK_GATE, 8'h00);
    i_light_stop_mode <= 1'b1;
    i_rst <= 1'b1;
    idle(3);
    i_rst <= 1'b0;
    i_light_stop_mode <= 1'b0;
    rd(ADDR_CLOCK_GATE, 8'h01);
    rd(ADDR_SYS_OPTIONS, 8'h00);
    idle(2);
    print_verdict();
  end
endmodule : analog_compare_control_tb

/* verif/analog_compare_monitor.sv */
`timescale 1ns/100ps
module analog_compare_monitor
  import analog_compare_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] o_rdata,
  input wire logic i_light_stop_mode,
  input wire logic i_deep_stop_mode,
  input wire logic [1:0] i_timer_pin_in,
  input wire logic [1:0] o_capture_in,
  input wire logic [1:0] o_timer_pin_connect,
  input wire logic [1:0] o_analog_enable,
  input wire logic o_irq
);
  // ********
  // Port relations
  // ********
  logic [7:0] wdata_q;
  logic [1:0] pin_q;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Delayed input copies
  always_ff @(posedge i_clock) begin
    wdata_q <= i_wdata;
    pin_q <= i_timer_pin_in;
  end
  chk_route_pin_cut:
    assert property (i_write && i_addr == ADDR_SYS_OPTIONS |=> o_timer_pin_connect == ~wdata_q[1:0])
    else $error("pin connect wrong");
  chk_capture_from_pin:
    assert property (o_timer_pin_connect == 2'h3 |=> o_capture_in == pin_q)
    else $error("capture input wrong");
  chk_stop_disable:
    assert property (i_light_stop_mode || i_deep_stop_mode |-> o_analog_enable == 2'h0)
    else $error("enabled in stop");
  chk_irq_from_flag:
    assert property (i_read && i_addr == ADDR_STATUS_ONE && !i_deep_stop_mode ##1
      (o_rdata[BIT_FLAG] && o_rdata[BIT_IRQ_ENABLE]) |-> o_irq) else $error("irq missing");
  chk_light_keep:
    assert property (i_light_stop_mode && !i_deep_stop_mode && o_irq |=> o_irq)
    else $error("state lost in stop");
  chk_stop_no_event:
    assert property ((i_light_stop_mode || i_deep_stop_mode) && !o_irq |=> !o_irq)
    else $error("event in stop");
  chk_deep_reset:
    assert property (i_deep_stop_mode |=> !o_irq [*2]) else $error("deep stop kept state");
  chk_reset_state:
    assert property ($fell(i_rst) |-> o_timer_pin_connect == 2'h3 && !o_irq)
    else $error("reset state wrong");
  chk_rdata_idle:
    assert property (!i_read |=> o_rdata == 8'h00) else $error("read data not idle");
endmodule : analog_compare_monitor
bind analog_compare_control analog_compare_monitor mon_u (.i_clock, .i_rst, .i_addr,
  .i_wdata, .i_write, .i_read, .o_rdata, .i_light_stop_mode, .i_deep_stop_mode,
  .i_timer_pin_in, .o_capture_in, .o_timer_pin_connect, .o_analog_enable, .o_irq);

/* verif/timer_pin_model.sv */
`timescale 1ns/100ps
// ********
// Timer pin drivers
// ********
module timer_pin_model (
  input wire logic i_clock,
  input wire logic [1:0] i_pin_connect,
  output logic [1:0] o_pin_level
);
  logic [1:0] pattern = 2'h1;
  // Outside driver one changes every cycle, driver two every second cycle; a cut-off pin shows the inverse
  always @(posedge i_clock) begin
    pattern <= pattern + 2'h1;
  end
  assign o_pin_level = pattern ^ ~i_pin_connect;
endmodule : timer_pin_model
